// >>> hdl/dmad_cfg.svh
// constants for the data-move / arithmetic opcode decoder
// assumes inclusion by every design file except the package, which uses none of these constants
`ifndef DMAD_CFG_SVH
`define DMAD_CFG_SVH
`define DMAD_OP_SEG_LOAD 8'h8e
`define DMAD_OP_SEG_STORE 8'h8c
`define DMAD_OP_TABLE 8'hd7
`define DMAD_OP_EADDR 8'h8d
`define DMAD_OP_LFP_DSEG 8'hc5
`define DMAD_OP_LFP_XSEG 8'hc4
`define DMAD_OP_FLG_TO_ACC 8'h9f
`define DMAD_OP_ACC_TO_FLG 8'h9e
`define DMAD_OP_PFX_CS 8'h2e
`define DMAD_OP_PFX_SS 8'h36
`define DMAD_OP_PFX_DSEG 8'h3e
`define DMAD_OP_PFX_XSEG 8'h26
`define DMAD_OP_UADJ_ADD 8'h37
`define DMAD_OP_PADJ_ADD 8'h27
`define DMAD_OP_UADJ_SUB 8'h3f
`define DMAD_OP_PADJ_SUB 8'h2f
`define DMAD_GRP1_TOP 6'h20
`define DMAD_GRP3_TOP 7'h7b
`define DMAD_ADD_TOP 6'h00
`define DMAD_ADC_TOP 6'h04
`define DMAD_SUB_TOP 6'h0a
`define DMAD_SUBB_TOP 6'h06
`define DMAD_ADDI_TOP 7'h02
`define DMAD_ADCI_TOP 7'h0a
`define DMAD_SUBI_TOP 7'h16
`define DMAD_SUBBI_TOP 7'h0e
`define DMAD_SUBF_ADD 3'h0
`define DMAD_SUBF_ADC 3'h2
`define DMAD_SUBF_SUBB 3'h3
`define DMAD_SUBF_SUB 3'h5
`define DMAD_SUBF_NEGATE 3'h3
`define DMAD_MOD_REG 2'h3
`define DMAD_CLK_2 6'h02
`define DMAD_CLK_3 6'h03
`define DMAD_CLK_4 6'h04
`define DMAD_CLK_6 6'h06
`define DMAD_CLK_7 6'h07
`define DMAD_CLK_8 6'h08
`define DMAD_CLK_10 6'h0a
`define DMAD_CLK_13 6'h0d
`define DMAD_CLK_15 6'h0f
`define DMAD_CLK_16 6'h10
`define DMAD_CLK_26 6'h1a
`endif

// >>> hdl/dmad_pkg.sv
// types for the data-move / arithmetic opcode decoder
// needs no include file; uses none of the dmad_cfg.svh constants
`default_nettype none
package dmad_pkg;
  typedef enum logic [4:0] {
    DMAD_NONE = 5'h00, DMAD_SEG_LOAD, DMAD_SEG_STORE, DMAD_TABLE, DMAD_EADDR,
    DMAD_LFP_DATA, DMAD_LFP_EXTRA, DMAD_FLG_TO_ACC, DMAD_ACC_TO_FLG, DMAD_PREFIX,
    DMAD_ADD, DMAD_ADC, DMAD_SUB, DMAD_SUBB, DMAD_NEGATE,
    DMAD_UADJ_ADD, DMAD_PADJ_ADD, DMAD_UADJ_SUB, DMAD_PADJ_SUB
  } dmad_op_t;
  typedef enum logic [1:0] {
    DMAD_SEG_EXTRA = 2'h0, DMAD_SEG_CS = 2'h1, DMAD_SEG_SS = 2'h2, DMAD_SEG_DATA = 2'h3
  } dmad_seg_t;
  typedef enum logic [1:0] {
    DMAD_IDLE = 2'h0, DMAD_NEED_MODRM = 2'h1, DMAD_DONE = 2'h3
  } dmad_state_t;
  // operand form; carry_in set for carry/borrow forms
  typedef struct packed {
    dmad_op_t op;
    logic word;
    logic reg_dest;
    logic sign_ext;
    logic has_imm;
    logic acc_form;
    logic carry_in;
    logic mem;
    logic illegal;
    logic seg_valid;
    dmad_seg_t seg;
    logic [5:0] clocks;
  } dmad_dec_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] mode;
    logic [2:0] subf;
    logic [2:0] rm;
  } dmad_insn_t;
  typedef struct packed {
    dmad_state_t st;
    dmad_insn_t insn;
    dmad_dec_t dec;
    logic out_valid;
  } dmad_state_struct_t;
endpackage
`default_nettype wire

// >>> hdl/dmad_opclass.sv
// first-byte classifier: is the opcode known, does it need an addressing byte
// assumes a purely combinational use inside the decoder top
`default_nettype none
`include "dmad_cfg.svh"
module dmad_opclass (
  input wire logic [7:0] opcode,
  output logic known,
  output logic needs_modrm
);
  import dmad_pkg::*;
  always_comb begin
    known = 1'b1;
    needs_modrm = 1'b0;
    if (opcode == `DMAD_OP_SEG_LOAD || opcode == `DMAD_OP_SEG_STORE || opcode == `DMAD_OP_EADDR ||
        opcode == `DMAD_OP_LFP_DSEG || opcode == `DMAD_OP_LFP_XSEG || opcode[7:2] == `DMAD_GRP1_TOP ||
        opcode[7:1] == `DMAD_GRP3_TOP || opcode[7:2] == `DMAD_ADD_TOP || opcode[7:2] == `DMAD_ADC_TOP ||
        opcode[7:2] == `DMAD_SUB_TOP || opcode[7:2] == `DMAD_SUBB_TOP) begin
      needs_modrm = 1'b1;
    end else if (opcode == `DMAD_OP_TABLE || opcode == `DMAD_OP_FLG_TO_ACC || opcode == `DMAD_OP_ACC_TO_FLG ||
        opcode == `DMAD_OP_PFX_CS || opcode == `DMAD_OP_PFX_SS || opcode == `DMAD_OP_PFX_DSEG ||
        opcode == `DMAD_OP_PFX_XSEG || opcode == `DMAD_OP_UADJ_ADD || opcode == `DMAD_OP_PADJ_ADD ||
        opcode == `DMAD_OP_UADJ_SUB || opcode == `DMAD_OP_PADJ_SUB || opcode[7:1] == `DMAD_ADDI_TOP ||
        opcode[7:1] == `DMAD_ADCI_TOP || opcode[7:1] == `DMAD_SUBI_TOP || opcode[7:1] == `DMAD_SUBBI_TOP) begin
      needs_modrm = 1'b0;
    end else begin
      known = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dmad_clocks.sv
// picks register or memory clock count from the addressing mode
// assumes both counts are already constants of the caller
`default_nettype none
`include "dmad_cfg.svh"
module dmad_clocks (
  input wire logic [1:0] mode,
  input wire logic [5:0] reg_clk,
  input wire logic [5:0] mem_clk,
  output logic [5:0] clocks,
  output logic mem
);
  assign mem = (mode != `DMAD_MOD_REG);
  assign clocks = mem ? mem_clk : reg_clk;
endmodule
`default_nettype wire

// >>> hdl/dmad_decoder.sv
// data-move / arithmetic opcode decoder, fed byte by byte from the prefetch queue
// assumes bytes arrive with valid/ready and the datapath takes one result per ready
`default_nettype none
`include "dmad_cfg.svh"
module dmad_decoder (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  output logic byte_ready,
  output dmad_pkg::dmad_dec_t dec,
  output logic dec_valid,
  input wire logic dec_ready
);
  import dmad_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  dmad_state_struct_t s_q, s_d;
  logic first_known, first_modrm;
  logic [5:0] arith_clk, arith_mem_clk, grp_clk;
  logic arith_mem, grp_mem;
  logic [7:0] op_now;
  logic [1:0] mode_now;
  logic [2:0] subf_now;
  logic take;

  // a second byte is decoded against the held opcode
  assign op_now = s_q.insn.opcode;
  assign mode_now = byte_data[7:6];
  assign subf_now = byte_data[5:3];
  assign take = byte_valid & byte_ready;
  // result must drain before the next opcode enters
  assign byte_ready = (s_q.st != DMAD_DONE);
  assign dec = s_q.dec;
  assign dec_valid = s_q.out_valid;

  dmad_opclass u_class (
    .opcode(byte_data),
    .known(first_known),
    .needs_modrm(first_modrm)
  );

  dmad_clocks u_arith (
    .mode(mode_now),
    .reg_clk(arith_clk),
    .mem_clk(arith_mem_clk),
    .clocks(grp_clk),
    .mem(grp_mem)
  );
  assign arith_mem = grp_mem;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic dmad_dec_t blank();
    dmad_dec_t d;
    d = '0;
    d.op = DMAD_NONE;
    d.seg = DMAD_SEG_DATA;
    return d;
  endfunction

  function automatic dmad_op_t arith_of(input logic [2:0] sf);
    dmad_op_t o;
    case (sf)
      `DMAD_SUBF_ADD: o = DMAD_ADD;
      `DMAD_SUBF_ADC: o = DMAD_ADC;
      `DMAD_SUBF_SUBB: o = DMAD_SUBB;
      `DMAD_SUBF_SUB: o = DMAD_SUB;
      default: o = DMAD_NONE;
    endcase
    return o;
  endfunction

  // counts that depend on the held opcode
  always_comb begin
    arith_clk = `DMAD_CLK_3;
    arith_mem_clk = `DMAD_CLK_10;
    case (op_now)
      `DMAD_OP_SEG_LOAD: begin
        arith_clk = `DMAD_CLK_2;
        arith_mem_clk = `DMAD_CLK_13;
      end
      `DMAD_OP_SEG_STORE: begin
        arith_clk = `DMAD_CLK_2;
        arith_mem_clk = `DMAD_CLK_15;
      end
      `DMAD_OP_EADDR: begin
        arith_clk = `DMAD_CLK_6;
        arith_mem_clk = `DMAD_CLK_6;
      end
      `DMAD_OP_LFP_DSEG, `DMAD_OP_LFP_XSEG: begin
        arith_clk = `DMAD_CLK_26;
        arith_mem_clk = `DMAD_CLK_26;
      end
      default: begin
        if (op_now[7:2] == `DMAD_GRP1_TOP) begin
          arith_clk = `DMAD_CLK_4;
          arith_mem_clk = `DMAD_CLK_16;
        end
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.out_valid && dec_ready) begin
      s_d.out_valid = 1'b0;
      s_d.st = DMAD_IDLE;
    end
    case (s_q.st)
      DMAD_IDLE: begin
        if (take) begin
          s_d.insn.opcode = byte_data;
          s_d.dec = blank();
          s_d.dec.word = byte_data[0];
          if (!first_known) begin
            s_d.dec.illegal = 1'b1;
            s_d.st = DMAD_DONE;
            s_d.out_valid = 1'b1;
          end else if (first_modrm) begin
            s_d.st = DMAD_NEED_MODRM;
          end else begin
            s_d.st = DMAD_DONE;
            s_d.out_valid = 1'b1;
            case (byte_data)
              `DMAD_OP_TABLE: begin
                s_d.dec.op = DMAD_TABLE;
                s_d.dec.word = 1'b0;
                s_d.dec.clocks = `DMAD_CLK_15;
              end
              `DMAD_OP_FLG_TO_ACC: begin
                s_d.dec.op = DMAD_FLG_TO_ACC;
                s_d.dec.clocks = `DMAD_CLK_2;
              end
              `DMAD_OP_ACC_TO_FLG: begin
                s_d.dec.op = DMAD_ACC_TO_FLG;
                s_d.dec.clocks = `DMAD_CLK_3;
              end
              `DMAD_OP_PFX_CS, `DMAD_OP_PFX_SS, `DMAD_OP_PFX_DSEG, `DMAD_OP_PFX_XSEG: begin
                s_d.dec.op = DMAD_PREFIX;
                s_d.dec.seg_valid = 1'b1;
                s_d.dec.seg = dmad_seg_t'(byte_data[4:3]);
                s_d.dec.clocks = `DMAD_CLK_2;
              end
              `DMAD_OP_UADJ_ADD: begin
                s_d.dec.op = DMAD_UADJ_ADD;
                s_d.dec.clocks = `DMAD_CLK_8;
              end
              `DMAD_OP_PADJ_ADD: begin
                s_d.dec.op = DMAD_PADJ_ADD;
                s_d.dec.word = 1'b0;
                s_d.dec.clocks = `DMAD_CLK_4;
              end
              `DMAD_OP_UADJ_SUB: begin
                s_d.dec.op = DMAD_UADJ_SUB;
                s_d.dec.clocks = `DMAD_CLK_7;
              end
              `DMAD_OP_PADJ_SUB: begin
                s_d.dec.op = DMAD_PADJ_SUB;
                s_d.dec.word = 1'b0;
                s_d.dec.clocks = `DMAD_CLK_4;
              end
              default: begin
                s_d.dec.acc_form = 1'b1;
                s_d.dec.has_imm = 1'b1;
                s_d.dec.clocks = byte_data[0] ? `DMAD_CLK_4 : `DMAD_CLK_3;
                case (byte_data[7:1])
                  `DMAD_ADDI_TOP: s_d.dec.op = DMAD_ADD;
                  `DMAD_ADCI_TOP: begin
                    s_d.dec.op = DMAD_ADC;
                    s_d.dec.carry_in = 1'b1;
                  end
                  `DMAD_SUBI_TOP: s_d.dec.op = DMAD_SUB;
                  `DMAD_SUBBI_TOP: begin
                    s_d.dec.op = DMAD_SUBB;
                    s_d.dec.carry_in = 1'b1;
                  end
                  default: s_d.dec.illegal = 1'b1;
                endcase
              end
            endcase
          end
        end
      end
      DMAD_NEED_MODRM: begin
        if (take) begin
          s_d.insn.mode = mode_now;
          s_d.insn.subf = subf_now;
          s_d.insn.rm = byte_data[2:0];
          s_d.st = DMAD_DONE;
          s_d.out_valid = 1'b1;
          s_d.dec.mem = arith_mem;
          s_d.dec.clocks = grp_clk;
          case (op_now)
            `DMAD_OP_SEG_LOAD: begin
              s_d.dec.op = DMAD_SEG_LOAD;
              s_d.dec.word = 1'b1;
            end
            `DMAD_OP_SEG_STORE: begin
              s_d.dec.op = DMAD_SEG_STORE;
              s_d.dec.word = 1'b1;
            end
            `DMAD_OP_EADDR: begin
              s_d.dec.op = DMAD_EADDR;
              s_d.dec.word = 1'b1;
              s_d.dec.mem = 1'b0;
            end
            `DMAD_OP_LFP_DSEG: begin
              s_d.dec.op = DMAD_LFP_DATA;
              s_d.dec.word = 1'b1;
              s_d.dec.illegal = (mode_now == `DMAD_MOD_REG);
            end
            `DMAD_OP_LFP_XSEG: begin
              s_d.dec.op = DMAD_LFP_EXTRA;
              s_d.dec.word = 1'b1;
              s_d.dec.illegal = (mode_now == `DMAD_MOD_REG);
            end
            default: begin
              if (op_now[7:2] == `DMAD_GRP1_TOP) begin
                s_d.dec.op = arith_of(subf_now);
                s_d.dec.has_imm = 1'b1;
                s_d.dec.sign_ext = op_now[1];
                s_d.dec.carry_in = (subf_now == `DMAD_SUBF_ADC) || (subf_now == `DMAD_SUBF_SUBB);
                s_d.dec.illegal = (arith_of(subf_now) == DMAD_NONE);
              end else if (op_now[7:1] == `DMAD_GRP3_TOP) begin
                s_d.dec.op = (subf_now == `DMAD_SUBF_NEGATE) ? DMAD_NEGATE : DMAD_NONE;
                s_d.dec.illegal = (subf_now != `DMAD_SUBF_NEGATE);
              end else begin
                s_d.dec.reg_dest = op_now[1];
                case (op_now[7:2])
                  `DMAD_ADD_TOP: s_d.dec.op = DMAD_ADD;
                  `DMAD_ADC_TOP: begin
                    s_d.dec.op = DMAD_ADC;
                    s_d.dec.carry_in = 1'b1;
                  end
                  `DMAD_SUB_TOP: s_d.dec.op = DMAD_SUB;
                  default: begin
                    s_d.dec.op = DMAD_SUBB;
                    s_d.dec.carry_in = 1'b1;
                  end
                endcase
              end
            end
          endcase
        end
      end
      DMAD_DONE: begin
      end
      default: s_d.st = DMAD_IDLE;
    endcase
    if (srst) begin
      s_d = '0;
      s_d.st = DMAD_IDLE;
      s_d.dec = blank();
    end
  end

  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seg_load_seq;
    s_q.st == DMAD_NEED_MODRM && op_now == `DMAD_OP_SEG_LOAD && take;
  endsequence

  seg_load_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    seg_load_seq |=> dec_valid && dec.op == DMAD_SEG_LOAD &&
      dec.clocks == ($past(mode_now) == `DMAD_MOD_REG ? `DMAD_CLK_2 : `DMAD_CLK_13))
    else $error("segment load count wrong");
  seg_store_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_NEED_MODRM && op_now == `DMAD_OP_SEG_STORE && take |=>
      dec.clocks == ($past(mode_now) == `DMAD_MOD_REG ? `DMAD_CLK_2 : `DMAD_CLK_15))
    else $error("segment store count wrong");
  table_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_IDLE && take && byte_data == `DMAD_OP_TABLE |=>
      dec_valid && dec.op == DMAD_TABLE && dec.clocks == `DMAD_CLK_15)
    else $error("translate decode wrong");
  far_ptr_reg_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_NEED_MODRM && take && op_now == `DMAD_OP_LFP_DSEG && mode_now == `DMAD_MOD_REG |=>
      dec.illegal)
    else $error("far pointer register mode accepted");
  prefix_seg_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_IDLE && take && byte_data == `DMAD_OP_PFX_SS |=>
      dec.seg_valid && dec.seg == DMAD_SEG_SS && dec.clocks == `DMAD_CLK_2)
    else $error("prefix segment wrong");
  acc_imm_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_IDLE && take && byte_data[7:1] == `DMAD_ADDI_TOP |=>
      dec.op == DMAD_ADD && dec.clocks == ($past(byte_data[0]) ? `DMAD_CLK_4 : `DMAD_CLK_3))
    else $error("accumulator add count wrong");
  negate_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_NEED_MODRM && take && op_now[7:1] == `DMAD_GRP3_TOP && subf_now == `DMAD_SUBF_NEGATE |=>
      dec.op == DMAD_NEGATE && dec.clocks == ($past(mode_now) == `DMAD_MOD_REG ? `DMAD_CLK_3 : `DMAD_CLK_10))
    else $error("negate count wrong");
  adjust_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.st == DMAD_IDLE && take && byte_data == `DMAD_OP_UADJ_ADD |=> dec.clocks == `DMAD_CLK_8)
    else $error("unpacked adjust count wrong");
  hold_result_a: assert property (@(posedge sys_clk) disable iff (srst)
    dec_valid && !dec_ready |=> dec_valid && $stable(dec))
    else $error("result dropped before taken");
endmodule
`default_nettype wire

// >>> testbench/dmad_exec_model.sv
// execution datapath model: takes decoded results with random stalls
// assumes one clock, sync reset; ready moves only after rising edges
`default_nettype none
module dmad_exec_model (
  input wire logic sys_clk,
  input wire logic srst,
  output logic dec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 51;
  // ----------------------------------------
  // take or stall
  // ----------------------------------------
  // stalls exercise the hold of a waiting result
  always @(posedge sys_clk) begin
    if (srst) begin
      dec_ready <= 1'b0;
    end else begin
      dec_ready <= ($random(seed) % 3) != 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_data_move_arith_opcode_decoder.sv
// bench for the opcode decoder: table of every covered opcode, then random ones
// assumes dmad_pkg compiled first and the datapath model beside it
`default_nettype none
module test_data_move_arith_opcode_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import dmad_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] byte_data = 8'h00;
  logic byte_valid = 1'b0;
  logic byte_ready;
  dmad_dec_t dec;
  logic dec_valid;
  logic dec_ready;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 51;
  logic [7:0] ops [43] = '{8'h8e, 8'h8c, 8'hd7, 8'h8d, 8'hc5, 8'hc4, 8'h9f, 8'h9e, 8'h2e, 8'h36, 8'h3e,
    8'h26, 8'h00, 8'h03, 8'h04, 8'h05, 8'h10, 8'h13, 8'h14, 8'h15, 8'h28, 8'h2b, 8'h2c, 8'h2d, 8'h18,
    8'h1b, 8'h1c, 8'h1d, 8'h80, 8'h81, 8'h82, 8'h83, 8'hf6, 8'hf7, 8'h37, 8'h27, 8'h3f, 8'h2f, 8'hf4,
    8'h01, 8'h12, 8'h29, 8'h1a};
  always #10 sys_clk = ~sys_clk;
  dmad_decoder dmad_decoder_i (.sys_clk(sys_clk), .srst(srst), .byte_data(byte_data),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .dec(dec), .dec_valid(dec_valid),
    .dec_ready(dec_ready));
  dmad_exec_model dmad_exec_model_i (.sys_clk(sys_clk), .srst(srst), .dec_ready(dec_ready));
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic dmad_op_t arith(input logic [2:0] f);
    case (f)
      3'h0: return DMAD_ADD;
      3'h2: return DMAD_ADC;
      3'h5: return DMAD_SUB;
      3'h3: return DMAD_SUBB;
      default: return DMAD_NONE;
    endcase
  endfunction
  function automatic logic needs_m(input logic [7:0] o);
    return (o inside {8'h8e, 8'h8c, 8'h8d, 8'hc5, 8'hc4, 8'hf6, 8'hf7}) ||
      (o[7:2] inside {6'h00, 6'h04, 6'h0a, 6'h06, 6'h20});
  endfunction
  function automatic dmad_dec_t expect_dec(input logic [7:0] o, input logic [7:0] m);
    dmad_dec_t e;
    logic r;
    r = (m[7:6] == 2'h3);
    e = '0;
    e.seg = DMAD_SEG_DATA;
    e.mem = !r;
    e.word = o[0];
    e.reg_dest = o[1];
    casez (o)
      8'h8e: begin e.op = DMAD_SEG_LOAD; e.clocks = r ? 6'h02 : 6'h0d; end
      8'h8c: begin e.op = DMAD_SEG_STORE; e.clocks = r ? 6'h02 : 6'h0f; end
      8'hd7: begin e.op = DMAD_TABLE; e.clocks = 6'h0f; end
      8'h8d: begin e.op = DMAD_EADDR; e.clocks = 6'h06; e.mem = 1'b0; end
      8'hc5: begin e.op = DMAD_LFP_DATA; e.clocks = 6'h1a; e.illegal = r; end
      8'hc4: begin e.op = DMAD_LFP_EXTRA; e.clocks = 6'h1a; e.illegal = r; end
      8'h9f: begin e.op = DMAD_FLG_TO_ACC; e.clocks = 6'h02; end
      8'h9e: begin e.op = DMAD_ACC_TO_FLG; e.clocks = 6'h03; end
      8'h2e, 8'h36, 8'h3e, 8'h26: begin
        e.op = DMAD_PREFIX;
        e.clocks = 6'h02;
        e.seg_valid = 1'b1;
        e.seg = dmad_seg_t'(o[4:3]);
      end
      8'h37: begin e.op = DMAD_UADJ_ADD; e.clocks = 6'h08; end
      8'h27: begin e.op = DMAD_PADJ_ADD; e.clocks = 6'h04; end
      8'h3f: begin e.op = DMAD_UADJ_SUB; e.clocks = 6'h07; end
      8'h2f: begin e.op = DMAD_PADJ_SUB; e.clocks = 6'h04; end
      8'b00???0??: begin
        e.op = arith(o[5:3]);
        e.illegal = (e.op == DMAD_NONE);
        e.clocks = r ? 6'h03 : 6'h0a;
      end
      8'b00???10?: begin
        e.op = arith(o[5:3]);
        e.illegal = (e.op == DMAD_NONE);
        e.has_imm = 1'b1;
        e.acc_form = 1'b1;
        e.clocks = o[0] ? 6'h04 : 6'h03;
      end
      8'b100000??: begin
        e.op = arith(m[5:3]);
        e.illegal = (e.op == DMAD_NONE);
        e.has_imm = 1'b1;
        e.clocks = r ? 6'h04 : 6'h10;
        e.sign_ext = o[1];
      end
      8'b1111011?: begin
        e.op = (m[5:3] == 3'h3) ? DMAD_NEGATE : DMAD_NONE;
        e.illegal = (e.op == DMAD_NONE);
        e.clocks = r ? 6'h03 : 6'h0a;
      end
      default: e.illegal = 1'b1;
    endcase
    e.carry_in = (e.op inside {DMAD_ADC, DMAD_SUBB});
    return e;
  endfunction
  // ----------------------------------------
  // drivers and compare
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send_byte(input logic [7:0] b);
    int k;
    byte_valid <= 1'b1;
    byte_data <= b;
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      if (byte_ready === 1'b1) break;
    end
    chk("byte taken", 8'h01, 8'(byte_ready));
  endtask
  task automatic run_insn(input logic [7:0] o, input logic [7:0] m);
    dmad_dec_t e;
    logic fp;
    int k;
    e = expect_dec(o, m);
    fp = (o == 8'hc5) || (o == 8'hc4);
    send_byte(o);
    if (needs_m(o)) send_byte(m);
    byte_valid <= 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      if (dec_valid === 1'b1 && dec_ready === 1'b1) break;
    end
    chk("dec_valid taken", 8'h01, 8'(dec_valid & dec_ready));
    chk("illegal", 8'(e.illegal), 8'(dec.illegal));
    if (!e.illegal || fp) chk("clocks", 8'(e.clocks), 8'(dec.clocks));
    if (!e.illegal || o == 8'hf4) chk("op", 8'(e.op), 8'(dec.op));
    if (needs_m(o) && !e.illegal) chk("mem", 8'(e.mem), 8'(dec.mem));
    if (e.op == DMAD_PREFIX) chk("seg", 8'(e.seg), 8'(dec.seg));
    if (e.op == DMAD_PREFIX) chk("seg_valid", 8'(e.seg_valid), 8'(dec.seg_valid));
    if (e.op inside {DMAD_ADD, DMAD_ADC, DMAD_SUB, DMAD_SUBB}) begin
      chk("word", 8'(e.word), 8'(dec.word));
      chk("has_imm", 8'(e.has_imm), 8'(dec.has_imm));
      chk("acc_form", 8'(e.acc_form), 8'(dec.acc_form));
      chk("carry_in", 8'(e.carry_in), 8'(dec.carry_in));
      if (o[7:2] == 6'h20) chk("sign_ext", 8'(e.sign_ext), 8'(dec.sign_ext));
      else if (needs_m(o)) chk("reg_dest", 8'(e.reg_dest), 8'(dec.reg_dest));
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #(20 * 30000);
    mismatches++;
    finish_test();
  end
  initial begin
    logic [7:0] m;
    int i;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    // every covered opcode twice, both addressing extremes
    foreach (ops[j]) begin
      run_insn(ops[j], {2'h3, j[2:0], 3'h0});
      run_insn(ops[j], {2'h0, j[2:0], 3'h6});
    end
    // group forms whose sub-fields the table never pairs with them
    run_insn(8'hf7, 8'hd8);
    run_insn(8'hf6, 8'h1e);
    run_insn(8'h83, 8'hd0);
    run_insn(8'h80, 8'h1e);
    run_insn(8'h81, 8'h06);
    run_insn(8'h81, 8'hc0);
    run_insn(8'h82, 8'h6e);
    $display("test table done");
    // interrupted instruction must leave no result behind
    send_byte(8'h8e);
    byte_valid <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("dec_valid after reset", 8'h00, 8'(dec_valid));
    chk("byte_ready after reset", 8'h01, 8'(byte_ready));
    chk("seg after reset", 8'(DMAD_SEG_DATA), 8'(dec.seg));
    run_insn(8'hd7, 8'h00);
    $display("test reset done");
    for (i = 0; i < 300; i++) begin
      m = 8'($random(seed));
      run_insn(ops[($unsigned($random(seed))) % 43], m);
    end
    $display("test random done");
    finish_test();
  end
endmodule
`default_nettype wire
